// file: logic/msq_pkg.sv
// How it works
// - A 16-bit address leaves a flip-flop every cycle; the instruction is sampled each edge.
// - The jump decodes in the same cycle, so a taken jump costs no cycle.
// - The instruction is seven bits: four opcode bits and three condition bits.
// - Sequential flow, conditional jumps, calls, returns and interrupt returns.
// - Four decrementing two's-complement counters; each sign bit is a jump condition.
// - The external flag level is a selectable jump condition.
// - Jump targets or offsets come from the data port: absolute, relative, indirect.
// - Sixty-four words of flip-flop RAM hold returns, registers and variables; vectors have their own store.
// - The RAM splits into subroutine stack, register stack and indirect area, configurable.
// - Eleven stored vectors: eight external, two internal, plus one for trap.
// - A stack limit violation and a counter underflow raise the internal interrupts.
// - Each interrupt has a mask bit; a group enable gates them all.
// - Requests are latched and stay pending after the source withdraws.
// - Transparent mode passes requests straight through without holding them.
// - Service outputs the stored vector and pushes the return address.
// - Download mode emits sequential addresses and ignores the instruction input.
// - In download mode the address advances only on the loader's ready handshake.
// - Four interrupt pins alternate between two phases to give eight request lines.
// - One control pin cycles through trap, tristate and reset phases.
package msq_pkg;

    localparam int ADDR_W    = 16;
    localparam int INSTR_W   = 7;
    localparam int RAM_DEPTH = 64;
    localparam int RAM_IW    = 6;
    localparam int NUM_IRQ   = 10;
    localparam int NUM_VEC   = 11;
    localparam int NUM_CNT   = 4;
    localparam int REG_AW    = 8;

    // Interrupt and vector slots
    localparam logic [3:0] IRQ_STACK = 4'h8;
    localparam logic [3:0] IRQ_UNDER = 4'h9;
    localparam logic [3:0] VEC_TRAP  = 4'hA;

    // Register port word offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_MASK     = 8'h01;
    localparam logic [7:0] REG_PEND     = 8'h02;
    localparam logic [7:0] REG_BOUND    = 8'h03;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_SPTR     = 8'h05;
    localparam logic [7:0] REG_PC       = 8'h06;
    localparam logic [7:0] REG_VEC_BASE = 8'h10;
    localparam logic [7:0] REG_VEC_LAST = 8'h1A;
    localparam logic [1:0] REG_RAM_SEL  = 2'b01;

    // Control field positions
    localparam int CTRL_TRANSP = 0;
    localparam int CTRL_WCS    = 1;
    localparam int CTRL_GRP    = 2;

    // Reset values
    localparam logic [5:0]  SUB_TOP_RST = 6'h20;
    localparam logic [5:0]  REG_TOP_RST = 6'h30;
    localparam logic [9:0]  MASK_RST    = 10'h000;
    localparam logic [15:0] ADDR_RST    = 16'h0000;

    // Condition codes; the top bit set selects a counter sign
    localparam logic [2:0] COND_ALWAYS = 3'h0;
    localparam logic [2:0] COND_FLAG   = 3'h1;
    localparam logic [2:0] COND_NFLAG  = 3'h2;
    localparam logic [2:0] COND_NEVER  = 3'h3;

    typedef enum logic [3:0] {
        OP_CONT  = 4'h0,
        OP_JABS  = 4'h1,
        OP_JREL  = 4'h2,
        OP_JIND  = 4'h3,
        OP_CALL  = 4'h4,
        OP_RET   = 4'h5,
        OP_RTI   = 4'h6,
        OP_LDC   = 4'h7,
        OP_DECC  = 4'h8,
        OP_PUSHR = 4'h9,
        OP_POPR  = 4'hA,
        OP_IEN   = 4'hB,
        OP_IDIS  = 4'hC,
        OP_WCS   = 4'hD
    } msq_op_e;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_WCS = 2'b01
    } msq_mode_e;

    typedef enum logic [1:0] {
        TP_TRAP = 2'b00,
        TP_TRI  = 2'b01,
        TP_RST  = 2'b11
    } msq_tphase_e;

    typedef struct packed {
        msq_op_e    opc;
        logic [2:0] cond;
    } msq_dec_s;

    typedef struct packed {
        logic [5:0] reg_top;
        logic [5:0] sub_top;
    } msq_bound_s;

endpackage

// file: logic/msq_irq.sv
`timescale 1ns/1ns
module msq_irq (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       phase,
    input  wire logic [3:0]                 ext_irq_pins,
    input  wire logic [1:0]                 int_src,
    input  wire logic                       transparent,
    input  wire logic [msq_pkg::NUM_IRQ-1:0] mask,
    input  wire logic [msq_pkg::NUM_IRQ-1:0] clr,
    output logic      [msq_pkg::NUM_IRQ-1:0] pend_q,
    output logic                            req_any,
    output logic      [3:0]                 req_idx
);
    import msq_pkg::*;

    logic [7:0]         ext_live_q;
    logic [NUM_IRQ-1:0] internal_irq_lines;
    logic [NUM_IRQ-1:0] pend_d;
    logic [NUM_IRQ-1:0] req_vec;
    logic [NUM_IRQ-1:0] eligible;

    // Pins carry lines 1-4 in phase 0 and 5-8 in phase 1
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_live_q <= 8'h00;
        end else if (phase) begin
            ext_live_q[7:4] <= ext_irq_pins;
        end else begin
            ext_live_q[3:0] <= ext_irq_pins;
        end
    end

    assign internal_irq_lines = {int_src, ext_live_q};

    // Set beats clear so a request arriving on a clear is kept
    assign pend_d   = transparent ? {int_src, 8'h00}
                    : ((pend_q & ~clr) | internal_irq_lines);
    assign req_vec  = transparent ? {pend_q[9:8], ext_live_q} : pend_q;
    assign eligible = req_vec & mask;

    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // Lowest line number wins
    always_comb begin
        req_any = |eligible;
        req_idx = 4'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                req_idx = 4'(i);
            end
        end
    end

endmodule

// file: logic/msq_top.sv
`timescale 1ns/1ns
module msq_top (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic [msq_pkg::INSTR_W-1:0] instr,
    input  wire logic [msq_pkg::ADDR_W-1:0]  data_in,
    input  wire logic [3:0]                 ext_irq_pins,
    input  wire logic                       flag,
    input  wire logic                       trap_tristate_reset_pin,
    input  wire logic                       wcs_ready,
    input  wire logic [msq_pkg::REG_AW-1:0]  reg_addr,
    input  wire logic [15:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [msq_pkg::ADDR_W-1:0]  addr_out,
    output logic                            addr_oe,
    output logic      [msq_pkg::ADDR_W-1:0]  data_out,
    output logic                            data_oe,
    output logic                            wcs_ack,
    output logic                            irq_phase,
    output logic      [1:0]                 ttr_phase,
    output logic      [15:0]                reg_rdata
);
    import msq_pkg::*;

    // Decode of the seven-bit instruction
    function automatic msq_dec_s decode(input logic [INSTR_W-1:0] ins);
        msq_dec_s d;
        d.opc  = msq_op_e'(ins[6:3]);
        d.cond = ins[2:0];
        return d;
    endfunction

    function automatic logic cond_met(input logic [2:0] c, input logic flg,
                                      input logic [NUM_CNT-1:0] sgn);
        logic r;
        r = 1'b0;
        if (c[2]) begin
            r = sgn[c[1:0]];
        end else begin
            case (c)
                COND_ALWAYS: r = 1'b1;
                COND_FLAG:   r = flg;
                COND_NFLAG:  r = ~flg;
                COND_NEVER:  r = 1'b0;
                default:     r = 1'b0;
            endcase
        end
        return r;
    endfunction

    logic [ADDR_W-1:0]  addr_q;
    logic [ADDR_W-1:0]  ram_q [RAM_DEPTH];
    logic [ADDR_W-1:0]  vec_q [NUM_VEC];
    logic [ADDR_W-1:0]  cnt_q [NUM_CNT];
    logic [RAM_IW-1:0]  sp_q;
    logic [RAM_IW-1:0]  rsp_q;
    msq_bound_s         bound_q;
    msq_mode_e          mode_q;
    msq_tphase_e        tphase_q;
    logic               grp_q;
    logic               transp_q;
    logic [NUM_IRQ-1:0] mask_q;
    logic               trap_q;
    logic               ttr_rst_q;
    logic               oe_q;
    logic               phase_q;
    logic [ADDR_W-1:0]  dout_q;
    logic               doe_q;
    logic               ack_q;
    logic [15:0]        rdata_q;

    wire rst_int = srst | ttr_rst_q;

    // Decode and selection wires
    msq_dec_s           dec;
    logic [NUM_CNT-1:0] signs;
    logic               cond_ok;
    logic [ADDR_W-1:0]  pc_inc;
    logic               sub_full;
    logic               sub_empty;
    logic               reg_full;
    logic               reg_empty;
    logic [ADDR_W-1:0]  sub_top_val;
    logic [ADDR_W-1:0]  reg_top_val;
    logic [NUM_IRQ-1:0] pend;
    logic               irq_any;
    logic [3:0]         irq_idx;
    logic               irq_take;
    logic               trap_take;

    assign dec         = decode(instr);
    assign pc_inc      = addr_q + 16'h0001;
    assign cond_ok     = cond_met(dec.cond, flag, signs);
    assign sub_full    = (sp_q == bound_q.sub_top);
    assign sub_empty   = (sp_q == 6'h00);
    assign reg_full    = (rsp_q == bound_q.reg_top);
    assign reg_empty   = (rsp_q == bound_q.sub_top);
    assign sub_top_val = ram_q[sp_q - 6'h01];
    assign reg_top_val = ram_q[rsp_q - 6'h01];
    assign trap_take   = trap_q & (mode_q == MODE_RUN);
    assign irq_take    = irq_any & grp_q & (mode_q == MODE_RUN) & ~trap_q;

    // Register port decode
    wire sel_ctrl  = (reg_addr == REG_CTRL);
    wire sel_mask  = (reg_addr == REG_MASK);
    wire sel_pend  = (reg_addr == REG_PEND);
    wire sel_bound = (reg_addr == REG_BOUND);
    wire sel_vec   = (reg_addr >= REG_VEC_BASE) && (reg_addr <= REG_VEC_LAST);
    wire sel_ram   = (reg_addr[7:6] == REG_RAM_SEL);
    wire [3:0] vec_widx = reg_addr[3:0];
    wire wr_ctrl   = reg_wr & sel_ctrl;
    wire wr_bound  = reg_wr & sel_bound;

    genvar g;
    generate
        for (g = 0; g < NUM_CNT; g++) begin : g_sign
            assign signs[g] = cnt_q[g][ADDR_W-1];
        end
    endgenerate

    // Next-address selection; interrupts pre-empt the instruction
    logic [ADDR_W-1:0] next_addr;
    logic [ADDR_W-1:0] push_val;
    logic              push_sub;
    logic              pop_sub;
    logic              push_reg;
    logic              pop_reg;
    logic              ld_cnt;
    logic              dec_cnt;
    logic              grp_set;
    logic              grp_clr;
    logic              enter_wcs;
    logic              advance;

    always_comb begin
        next_addr = pc_inc;
        push_val  = pc_inc;
        push_sub  = 1'b0;
        pop_sub   = 1'b0;
        push_reg  = 1'b0;
        pop_reg   = 1'b0;
        ld_cnt    = 1'b0;
        dec_cnt   = 1'b0;
        grp_set   = 1'b0;
        grp_clr   = 1'b0;
        enter_wcs = 1'b0;
        advance   = 1'b0;
        if (mode_q == MODE_WCS) begin
            advance   = wcs_ready;
            next_addr = wcs_ready ? pc_inc : addr_q;
        end else if (trap_take) begin
            next_addr = vec_q[VEC_TRAP];
            push_val  = addr_q;
            push_sub  = 1'b1;
            grp_clr   = 1'b1;
        end else if (irq_take) begin
            next_addr = vec_q[irq_idx];
            push_val  = addr_q;
            push_sub  = 1'b1;
            grp_clr   = 1'b1;
        end else begin
            case (dec.opc)
                OP_JABS: if (cond_ok) next_addr = data_in;
                OP_JREL: if (cond_ok) next_addr = addr_q + data_in;
                OP_JIND: if (cond_ok) next_addr = ram_q[data_in[RAM_IW-1:0]];
                OP_CALL: begin
                    if (cond_ok && !sub_full) begin
                        next_addr = data_in;
                        push_sub  = 1'b1;
                    end
                end
                OP_RET: begin
                    if (cond_ok && !sub_empty) begin
                        next_addr = sub_top_val;
                        pop_sub   = 1'b1;
                    end
                end
                OP_RTI: begin
                    grp_set = 1'b1;
                    if (!sub_empty) begin
                        next_addr = sub_top_val;
                        pop_sub   = 1'b1;
                    end
                end
                OP_LDC:   ld_cnt    = 1'b1;
                OP_DECC:  dec_cnt   = 1'b1;
                OP_PUSHR: push_reg  = ~reg_full;
                OP_POPR:  pop_reg   = ~reg_empty;
                OP_IEN:   grp_set   = 1'b1;
                OP_IDIS:  grp_clr   = 1'b1;
                OP_WCS:   enter_wcs = 1'b1;
                default:  next_addr = pc_inc;
            endcase
        end
    end

    // Stack limit violations and counter underflow feed the internal lines
    wire inst_run  = (mode_q == MODE_RUN) & ~trap_take & ~irq_take;
    wire stack_err = ((trap_take | irq_take) & sub_full)
                   | (inst_run & (((dec.opc == OP_CALL) & cond_ok & sub_full)
                   | ((dec.opc == OP_RET) & cond_ok & sub_empty)
                   | ((dec.opc == OP_RTI) & sub_empty)
                   | ((dec.opc == OP_PUSHR) & reg_full)
                   | ((dec.opc == OP_POPR) & reg_empty)));
    wire underflow = dec_cnt & (cnt_q[dec.cond[1:0]] == 16'h0000);
    wire push_ok   = push_sub & ~sub_full;

    wire [NUM_IRQ-1:0] svc_clr = irq_take ? (NUM_IRQ'(1) << irq_idx) : '0;
    wire [NUM_IRQ-1:0] sw_clr  = (reg_wr & sel_pend) ? reg_wdata[NUM_IRQ-1:0] : '0;

    msq_irq u_irq (
        .clk          (clk),
        .rst          (rst_int),
        .phase        (phase_q),
        .ext_irq_pins (ext_irq_pins),
        .int_src      ({underflow, stack_err}),
        .transparent  (transp_q),
        .mask         (mask_q),
        .clr          (svc_clr | sw_clr),
        .pend_q       (pend),
        .req_any      (irq_any),
        .req_idx      (irq_idx)
    );

    // Pin phase sequencing runs on the external reset only
    always_ff @(posedge clk) begin
        if (srst) begin
            tphase_q  <= TP_TRAP;
            ttr_rst_q <= 1'b0;
            oe_q      <= 1'b1;
        end else begin
            case (tphase_q)
                TP_TRAP: tphase_q <= TP_TRI;
                TP_TRI:  tphase_q <= TP_RST;
                TP_RST:  tphase_q <= TP_TRAP;
                default: tphase_q <= TP_TRAP;
            endcase
            ttr_rst_q <= (tphase_q == TP_RST) & trap_tristate_reset_pin;
            if (tphase_q == TP_TRI) begin
                oe_q <= ~trap_tristate_reset_pin;
            end
        end
    end

    // Trap is sticky until taken; a new sample wins over the take
    always_ff @(posedge clk) begin
        if (rst_int) begin
            trap_q  <= 1'b0;
            phase_q <= 1'b0;
        end else begin
            trap_q  <= ((tphase_q == TP_TRAP) & trap_tristate_reset_pin)
                       | (trap_q & ~trap_take);
            phase_q <= ~phase_q;
        end
    end

    // Address, mode and enables
    always_ff @(posedge clk) begin
        if (rst_int) begin
            addr_q   <= ADDR_RST;
            mode_q   <= MODE_RUN;
            grp_q    <= 1'b0;
            transp_q <= 1'b0;
            mask_q   <= MASK_RST;
            ack_q    <= 1'b0;
        end else begin
            addr_q <= next_addr;
            ack_q  <= advance;
            if (wr_ctrl) begin
                transp_q <= reg_wdata[CTRL_TRANSP];
                mode_q   <= reg_wdata[CTRL_WCS] ? MODE_WCS : MODE_RUN;
                grp_q    <= reg_wdata[CTRL_GRP];
            end else begin
                if (enter_wcs) mode_q <= MODE_WCS;
                if (grp_set) grp_q <= 1'b1;
                else if (grp_clr) grp_q <= 1'b0;
            end
            if (reg_wr && sel_mask) mask_q <= reg_wdata[NUM_IRQ-1:0];
        end
    end

    // Pointers restart whenever the partition moves, else stale entries leak
    always_ff @(posedge clk) begin
        if (rst_int) begin
            bound_q <= '{reg_top: REG_TOP_RST, sub_top: SUB_TOP_RST};
            sp_q    <= 6'h00;
            rsp_q   <= SUB_TOP_RST;
        end else if (wr_bound) begin
            bound_q <= reg_wdata[11:0];
            sp_q    <= 6'h00;
            rsp_q   <= reg_wdata[5:0];
        end else begin
            if (push_ok) sp_q <= sp_q + 6'h01;
            else if (pop_sub) sp_q <= sp_q - 6'h01;
            if (push_reg) rsp_q <= rsp_q + 6'h01;
            else if (pop_reg) rsp_q <= rsp_q - 6'h01;
        end
    end

    // RAM: the sequencer's own write beats a software write
    always_ff @(posedge clk) begin
        if (push_ok) begin
            ram_q[sp_q] <= push_val;
        end else if (push_reg) begin
            ram_q[rsp_q] <= data_in;
        end else if (reg_wr && sel_ram) begin
            ram_q[reg_addr[RAM_IW-1:0]] <= reg_wdata;
        end
    end

    // Vectors and counters
    always_ff @(posedge clk) begin
        if (rst_int) begin
            for (int i = 0; i < NUM_VEC; i++) vec_q[i] <= 16'h0000;
            for (int i = 0; i < NUM_CNT; i++) cnt_q[i] <= 16'h0000;
        end else begin
            if (reg_wr && sel_vec) vec_q[vec_widx] <= reg_wdata;
            if (ld_cnt) cnt_q[dec.cond[1:0]] <= data_in;
            else if (dec_cnt) cnt_q[dec.cond[1:0]] <= cnt_q[dec.cond[1:0]] - 16'h0001;
        end
    end

    // Data port drives only in the cycle after a register pop
    always_ff @(posedge clk) begin
        if (rst_int) begin
            dout_q <= 16'h0000;
            doe_q  <= 1'b0;
        end else begin
            doe_q  <= pop_reg;
            dout_q <= pop_reg ? reg_top_val : 16'h0000;
        end
    end

    // Read data valid only in the cycle after the strobe
    wire [15:0] rd_status = {10'h000, mode_q == MODE_WCS, grp_q, signs};
    wire [15:0] rd_ctrl   = {13'h0000, grp_q, mode_q == MODE_WCS, transp_q};
    wire [15:0] rd_mux    = sel_ctrl   ? rd_ctrl :
                            sel_mask   ? {6'h00, mask_q} :
                            sel_pend   ? {6'h00, pend} :
                            sel_bound  ? {4'h0, bound_q} :
                            (reg_addr == REG_STATUS) ? rd_status :
                            (reg_addr == REG_SPTR)   ? {2'h0, rsp_q, 2'h0, sp_q} :
                            (reg_addr == REG_PC)     ? addr_q :
                            sel_vec    ? vec_q[vec_widx] :
                            sel_ram    ? ram_q[reg_addr[RAM_IW-1:0]] : 16'h0000;

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign addr_out  = addr_q;
    assign addr_oe   = oe_q;
    assign data_out  = dout_q;
    assign data_oe   = doe_q;
    assign wcs_ack   = ack_q;
    assign irq_phase = phase_q;
    assign ttr_phase = tphase_q;
    assign reg_rdata = rdata_q;

endmodule

// file: test/msq_assertions.sv
`timescale 1ns/1ns
module msq_assertions (
    input wire logic                        clk,
    input wire logic                        srst,
    input wire logic [msq_pkg::INSTR_W-1:0] instr,
    input wire logic [msq_pkg::ADDR_W-1:0]  data_in,
    input wire logic                        flag,
    input wire logic                        wcs_ready,
    input wire logic [msq_pkg::ADDR_W-1:0]  addr_out,
    input wire logic                        addr_oe,
    input wire logic                        wcs_ack,
    input wire logic                        irq_phase,
    input wire logic [1:0]                  ttr_phase
);
    import msq_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Flow decisions land on the very next address, no bubble
    a_seq_next: assert property (instr == 7'h00 |=> addr_out == $past(addr_out) + 16'h0001)
        else $error("continue did not step the address");
    a_jump_abs: assert property (instr == 7'h08 |=> addr_out == $past(data_in))
        else $error("absolute jump missed its target");
    a_jump_flag: assert property (instr == 7'h09 |=>
        addr_out == ($past(flag) ? $past(data_in) : $past(addr_out) + 16'h0001))
        else $error("flag jump took the wrong path");
    a_call_target: assert property (instr == 7'h20 |=> addr_out == $past(data_in))
        else $error("call missed its target");
    // Reset must win even while the sequencer runs
    a_reset_vals: assert property (disable iff (1'b0) srst |=> addr_out == 16'h0000 && addr_oe)
        else $error("reset did not clear the address");
    // Pin multiplexing phases
    a_phase_flip: assert property (!$past(srst) |-> irq_phase != $past(irq_phase))
        else $error("interrupt pin phase stalled");
    a_ttr_order: assert property (!$past(srst) |-> ttr_phase ==
        ($past(ttr_phase) == 2'b00 ? 2'b01 : $past(ttr_phase) == 2'b01 ? 2'b11 : 2'b00))
        else $error("control pin phase out of order");
    // Acknowledge only follows a loader ready
    a_ack_after: assert property (wcs_ack |-> $past(wcs_ready))
        else $error("download acknowledge without ready");
    c_call: cover property (instr == 7'h20);
    c_ack: cover property (wcs_ack);
    c_flag: cover property (instr == 7'h09 && flag);
endmodule

// file: test/msq_partner.sv
`timescale 1ns/1ns
module msq_partner (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       irq_phase,
    input  wire logic [7:0] lines,
    input  wire logic       paced,
    output logic      [3:0] ext_irq_pins,
    output logic            wcs_ready
);
    logic [2:0] pace_q;
    // Lines 1-4 ride phase 0, lines 5-8 ride phase 1
    assign ext_irq_pins = irq_phase ? lines[7:4] : lines[3:0];
    // Loader runs five ready cycles, then stalls three to test slow pacing
    always_ff @(posedge clk) begin
        pace_q    <= srst ? 3'h0 : pace_q + 3'h1;
        wcs_ready <= !srst && paced && (pace_q < 3'h5);
    end
endmodule

// file: test/msq_top_test.sv
`timescale 1ns/1ns
module msq_top_test;
    import msq_pkg::*;
    typedef struct {bit rd; int due; logic [15:0] val;} msq_note_s;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic [INSTR_W-1:0] instr = 7'h10;
    logic [ADDR_W-1:0]  data_in = 16'h0000;
    logic               flag = 1'b0;
    logic [REG_AW-1:0]  reg_addr = 8'h00;
    logic [15:0]        reg_wdata = 16'h0000;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [7:0]         lines = 8'h00;
    logic               paced = 1'b0;
    logic [3:0]         ext_irq_pins;
    logic               wcs_ready;
    logic [ADDR_W-1:0]  addr_out;
    logic               addr_oe;
    logic               wcs_ack;
    logic               irq_phase;
    logic [1:0]         ttr_phase;
    logic [15:0]        reg_rdata;
    logic [15:0]        pc = 16'h0000;
    msq_note_s          notes[$];
    int                 cyc = 0;
    int                 mismatches = 0;
    int                 check_count = 0;

    always #2 clk = ~clk;

    msq_top u_msq_top (.clk(clk), .srst(srst), .instr(instr), .data_in(data_in),
        .ext_irq_pins(ext_irq_pins), .flag(flag), .trap_tristate_reset_pin(1'b0),
        .wcs_ready(wcs_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .addr_out(addr_out), .addr_oe(addr_oe), .data_out(), .data_oe(),
        .wcs_ack(wcs_ack), .irq_phase(irq_phase), .ttr_phase(ttr_phase), .reg_rdata(reg_rdata));
    msq_partner u_msq_partner (.clk(clk), .srst(srst), .irq_phase(irq_phase), .lines(lines),
        .paced(paced), .ext_irq_pins(ext_irq_pins), .wcs_ready(wcs_ready));

    task automatic cmp(input logic [15:0] got, input logic [15:0] e);
        check_count++;
        if (got !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic chk_addr(input logic [15:0] e); cmp(addr_out, e); endtask
    task automatic chk_data(input logic [15:0] e); cmp(reg_rdata, e); endtask
    task automatic note(input bit rd, input int dly, input logic [15:0] v);
        notes.push_back('{rd, cyc + dly, v});
    endtask
    // One sequencer cycle; the address shows one edge after the instruction is taken
    task automatic go(input logic [6:0] i, input logic [15:0] d, input logic [15:0] e,
                      input logic fv = 1'b0);
        @(posedge clk);
        {instr, data_in, flag} <= {i, d, fv};
        note(1'b0, 2, e);
        pc = e;
    endtask
    // Register cycles park the sequencer on a zero relative jump
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {instr, data_in, reg_addr, reg_wdata, reg_wr} <= {7'h10, 16'h0000, a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        {instr, data_in, reg_addr, reg_rd} <= {7'h10, 16'h0000, a, 1'b1};
        note(1'b1, 2, e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Observer retires every note that falls due this cycle
    always @(negedge clk) begin
        cyc = cyc + 1;
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            if (notes[0].rd) chk_data(notes[0].val);
            else chk_addr(notes[0].val);
            void'(notes.pop_front());
        end
    end

    // Watchdog against a hung sequence
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        summarize();
    end

    initial begin
        logic [15:0] t;
        logic [15:0] r;
        int          f;
        void'($urandom(32'h1170));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(REG_PC, ADDR_RST);
        rd(8'h30, 16'h0000);
        $display("done reset");
        go(7'h00, 16'h0000, pc + 16'h0001);
        for (int c = 0; c < 4; c++) begin
            f = $urandom % 2;
            t = 16'($urandom);
            go({4'h1, c[2:0]}, t, (c == 0 || (c == 1 && f == 1) || (c == 2 && f == 0)) ? t
               : pc + 16'h0001, f[0]);
        end
        t = 16'($urandom);
        go(7'h10, t, pc + t);
        wr(8'h7C, t);
        go(7'h18, 16'h003C, t);
        r = pc + 16'h0001;
        t = 16'($urandom);
        go(7'h20, t, t);
        go(7'h00, 16'h0000, t + 16'h0001);
        go(7'h28, 16'h0000, r);
        go(7'h48, t, pc + 16'h0001);
        $display("done flow");
        for (int k = 0; k < 4; k++) begin
            t = 16'($urandom);
            go({5'h0E, k[1:0]}, 16'h0001, pc + 16'h0001);
            go({5'h10, k[1:0]}, 16'h0000, pc + 16'h0001);
            go({5'h03, k[1:0]}, t, pc + 16'h0001);
            go({5'h10, k[1:0]}, 16'h0000, pc + 16'h0001);
            go({5'h03, k[1:0]}, t, t);
        end
        rd(REG_PEND, 16'h0200);
        rd(REG_STATUS, 16'h000F);
        wr(REG_PEND, 16'h03FF);
        $display("done counters");
        t = 16'($urandom);
        wr(REG_VEC_BASE + 8'h01, t);
        wr(REG_MASK, 16'h0002);
        wr(REG_CTRL, 16'h0004);
        lines <= 8'h02;
        repeat (2) @(posedge clk);
        lines <= 8'h00;
        for (int n = 0; n < 12 && addr_out !== t; n++) @(posedge clk);
        if (addr_out !== t) begin
            mismatches++;
            summarize();
        end
        go(7'h10, 16'h0000, t);
        rd(REG_PEND, 16'h0002);
        rd(REG_STATUS, 16'h000F);
        rd(REG_SPTR, 16'h2101);
        wr(REG_CTRL, 16'h0004);
        lines <= 8'h04;
        repeat (2) @(posedge clk);
        lines <= 8'h00;
        go(7'h10, 16'h0000, pc);
        rd(REG_PEND, 16'h0004);
        $display("done interrupts");
        wr(REG_CTRL, 16'h0002);
        paced <= 1'b1;
        repeat (16) begin
            @(posedge clk);
            {instr, data_in} <= {7'h18, 16'($urandom)};
            if (wcs_ready) pc = pc + 16'h0001;
            note(1'b0, 1, pc);
        end
        repeat (3) @(posedge clk);
        $display("done download");
        summarize();
    end
endmodule

bind msq_top msq_assertions u_msq_assertions (.clk(clk), .srst(srst), .instr(instr),
    .data_in(data_in), .flag(flag), .wcs_ready(wcs_ready), .addr_out(addr_out),
    .addr_oe(addr_oe), .wcs_ack(wcs_ack), .irq_phase(irq_phase), .ttr_phase(ttr_phase));
